// >>> hw/crypto_selftest_fw_auth.sv
// Self-test, firmware authentication and diagnostic supervisor
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "selftest_params.svh"
module crypto_selftest_fw_auth #(
   parameter int unsigned FLASH_AW = 16
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // Wishbone slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   // Flash image reader
   output logic      [FLASH_AW-1:0]     flash_addr_o,
   output logic                         flash_rd_o,
   input  wire logic [7:0]              flash_data_i,
   input  wire logic                    flash_valid_i,
   input  wire logic                    flash_last_i,
   // Engine known-answer test port
   output logic                         kat_start_o,
   output logic      [1:0]              kat_sel_o,
   output logic                         kat_negative_o,
   input  wire logic                    kat_done_i,
   input  wire logic                    kat_match_i,
   // Hash engine digest result
   input  wire logic                    hash_done_i,
   input  wire logic [31:0]             hash_digest_i,
   // Firmware receive
   input  wire logic                    fw_start_i,
   input  wire logic                    fw_end_i,
   input  wire logic [31:0]             fw_embedded_digest_i,
   output logic                         fw_hash_en_o,
   output logic                         fw_resp_valid_o,
   output logic      [31:0]             fw_resp_code_o,
   // System
   input  wire logic                    io_msg_active_i,
   input  wire logic                    auth_ok_i,
   output logic                         engines_enable_o,
   output logic                         crypto_service_en_o,
   output logic                         data_out_en_o,
   output logic                         diag_mode_o,
   output logic      [2:0]              led_o
);
   import selftest_pkg::*;

   // ------------------------------------------------------------
   // State and status
   // ------------------------------------------------------------
   state_t          state_ff;
   state_t          nxt_state;
   logic [1:0]      bla_ff;
   logic [1:0]      enc_ff;
   logic [7:0]      eng_ff;
   logic [31:0]     crc_ff;
   logic [31:0]     crc_next;
   logic [31:0]     crc_ref_ff;
   logic [FLASH_AW-1:0] addr_ff;
   logic [1:0]      kat_idx_ff;
   logic            kat_busy_ff;
   logic            kat_neg_ff;
   logic            diag_done_ff;
   logic            diag_pass_ff;
   logic            diag_hmac_ff;
   logic [31:0]     digest_ff;
   fw_state_t       fw_ff;
   logic [31:0]     resp_ff;
   logic            resp_v_ff;
   logic            ack_ff;
   logic [31:0]     rdata_ff;
   logic            wb_req;
   logic            wr;
   logic            kat_fail;
   crc32_step u_crc (
      .crc_i  (crc_ff),
      .data_i (flash_data_i),
      .crc_o  (crc_next)
   );
   assign wb_req   = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wr       = wb_req & wb_we_i;
   assign kat_fail = kat_done_i & (kat_match_i == kat_neg_ff);
   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_CRC: begin
            if (flash_valid_i && flash_last_i) begin
               nxt_state = (crc_next == crc_ref_ff) ? ST_KAT : ST_FATAL;
            end
         end
         ST_KAT: begin
            if (kat_fail) begin
               nxt_state = ST_FATAL;
            end else if (kat_done_i && kat_idx_ff == 2'(`NUM_KAT - 1)) begin
               nxt_state = ST_READY;
            end
         end
         ST_READY: begin
            if (wr && wb_adr_i == `REG_DIAG && wb_dat_i[0]
                && !io_msg_active_i && auth_ok_i) begin
               nxt_state = ST_DIAG;
            end
         end
         // Diagnostic mode left only by reset
         ST_DIAG:  nxt_state = ST_DIAG;
         ST_FATAL: nxt_state = ST_FATAL;
         default:  nxt_state = ST_FATAL;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= ST_CRC;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------
   // Firmware integrity
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         crc_ff  <= `CRC_INIT;
         addr_ff <= '0;
      end else if (state_ff == ST_CRC && flash_valid_i) begin
         crc_ff  <= crc_next;
         addr_ff <= addr_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         crc_ref_ff <= ~`CRC_INIT;
      end else if (wr && wb_adr_i == `REG_CRC_REF && state_ff != ST_CRC) begin
         crc_ref_ff <= wb_dat_i;
      end
   end

   // ------------------------------------------------------------
   // Known-answer tests
   // ------------------------------------------------------------
   // Walk AES, XTS, key wrap, HMAC
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         kat_idx_ff  <= 2'h0;
         kat_busy_ff <= 1'b0;
         kat_neg_ff  <= 1'b0;
      end else if (state_ff == ST_KAT) begin
         kat_neg_ff <= 1'b0;
         if (!kat_busy_ff) begin
            kat_busy_ff <= 1'b1;
         end else if (kat_done_i) begin
            kat_busy_ff <= 1'b0;
            kat_idx_ff  <= kat_idx_ff + 2'h1;
         end
      end else if (state_ff == ST_READY && nxt_state == ST_DIAG) begin
         kat_neg_ff  <= wb_dat_i[1];
         kat_idx_ff  <= wb_dat_i[5:4];
         kat_busy_ff <= 1'b0;
      end else if (state_ff == ST_DIAG && !diag_done_ff) begin
         kat_busy_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Failure fields
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bla_ff <= 2'h0;
         enc_ff <= 2'h0;
         eng_ff <= 8'h00;
      end else if (state_ff == ST_CRC && nxt_state == ST_FATAL) begin
         bla_ff <= `BLA_FAIL;
      end else if (state_ff == ST_CRC && nxt_state == ST_KAT) begin
         bla_ff <= `BLA_OK;
      end else if (state_ff == ST_KAT && kat_fail) begin
         enc_ff <= `ENC_FAIL;
         eng_ff <= 8'h01 << kat_idx_ff;
      end else if (state_ff == ST_KAT && nxt_state == ST_READY) begin
         enc_ff <= `ENC_OK;
      end
   end

   // ------------------------------------------------------------
   // Diagnostics
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         diag_done_ff <= 1'b0;
         diag_pass_ff <= 1'b0;
         diag_hmac_ff <= 1'b0;
         digest_ff    <= 32'h00000000;
      end else if (state_ff == ST_READY && nxt_state == ST_DIAG) begin
         diag_hmac_ff <= wb_dat_i[2];
      end else if (state_ff == ST_DIAG && !diag_done_ff) begin
         if (diag_hmac_ff && hash_done_i) begin
            digest_ff    <= hash_digest_i;
            diag_done_ff <= 1'b1;
            diag_pass_ff <= 1'b1;
         end else if (!diag_hmac_ff && kat_busy_ff && kat_done_i) begin
            diag_done_ff <= 1'b1;
            diag_pass_ff <= (kat_match_i != kat_neg_ff);
         end
      end
   end

   // ------------------------------------------------------------
   // Firmware image authentication
   // ------------------------------------------------------------
   // Hash image, compare digest
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fw_ff     <= FW_IDLE;
         resp_ff   <= `RESP_OK;
         resp_v_ff <= 1'b0;
      end else begin
         resp_v_ff <= 1'b0;
         case (fw_ff)
            FW_IDLE: begin
               if (fw_start_i && state_ff == ST_READY && auth_ok_i) begin
                  fw_ff <= FW_RECV;
               end
            end
            FW_RECV: begin
               if (fw_end_i) begin
                  fw_ff <= FW_WAIT;
               end
            end
            FW_WAIT: begin
               if (hash_done_i) begin
                  fw_ff     <= FW_IDLE;
                  resp_v_ff <= 1'b1;
                  resp_ff   <= (hash_digest_i == fw_embedded_digest_i) ?
                               `RESP_OK : `RESP_AUTH_FAIL;
               end
            end
            default: fw_ff <= FW_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------
   // Status reads need no login
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h00000000;
      end else begin
         ack_ff <= wb_req;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               `REG_STATUS:  rdata_ff <= {13'h0000, state_ff, eng_ff,
                                          4'h0, enc_ff, bla_ff};
               `REG_DIAG:    rdata_ff <= {29'h00000000, diag_pass_ff,
                                          diag_done_ff, diag_mode_o};
               `REG_FW_RESP: rdata_ff <= resp_ff;
               `REG_DIGEST:  rdata_ff <= (state_ff == ST_DIAG) ?
                                         digest_ff : 32'h00000000;
               `REG_LOGIN:   rdata_ff <= {31'h00000000, auth_ok_i};
               `REG_CRC_REF: rdata_ff <= crc_ref_ff;
               default:      rdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign wb_ack_o        = ack_ff;
   assign wb_dat_o        = rdata_ff;
   assign flash_addr_o    = addr_ff;
   assign flash_rd_o      = (state_ff == ST_CRC);
   assign kat_start_o     = ((state_ff == ST_KAT) ||
                             (state_ff == ST_DIAG && !diag_hmac_ff
                              && !diag_done_ff)) && !kat_busy_ff;
   assign kat_sel_o       = kat_idx_ff;
   assign kat_negative_o  = kat_neg_ff;
   assign fw_hash_en_o    = (fw_ff != FW_IDLE);
   assign fw_resp_valid_o = resp_v_ff;
   assign fw_resp_code_o  = resp_ff;
   assign diag_mode_o     = (state_ff == ST_DIAG);
   assign engines_enable_o    = (state_ff == ST_READY);
   assign crypto_service_en_o = (state_ff == ST_READY) & auth_ok_i;
   // No data out in test or error
   assign data_out_en_o       = (state_ff == ST_READY) & auth_ok_i;
   assign led_o = {state_ff == ST_FATAL, state_ff == ST_READY,
                   state_ff == ST_CRC || state_ff == ST_KAT};
   logic unused_ok;
   assign unused_ok = &{1'b0, wb_sel_i, `ENC_OK};
endmodule
`default_nettype wire

// >>> hw/selftest_params.svh
// Constants for the self-test and firmware authentication supervisor
`ifndef SELFTEST_PARAMS_SVH
`define SELFTEST_PARAMS_SVH
`define REG_STATUS        8'h00
`define REG_CTRL          8'h04
`define REG_DIAG          8'h08
`define REG_FW_RESP       8'h0C
`define REG_DIGEST        8'h10
`define REG_LOGIN         8'h14
`define REG_CRC_REF       8'h18
`define BLA_OK            2'h1
`define BLA_FAIL          2'h2
`define ENC_FAIL          2'h1
`define ENC_OK            2'h2
`define ENG_AES           8'h01
`define ENG_XTS           8'h02
`define ENG_KWRAP         8'h04
`define ENG_HASH          8'h08
`define RESP_OK           32'h00000000
`define RESP_AUTH_FAIL    32'h0000000E
`define CRC_INIT          32'hFFFFFFFF
`define CRC_POLY          32'hEDB88320
`define NUM_KAT           4
`endif

// >>> hw/selftest_pkg.sv
// Types for the self-test supervisor
package selftest_pkg;
   typedef enum logic [2:0] {
      ST_CRC   = 3'b000,
      ST_KAT   = 3'b001,
      ST_READY = 3'b010,
      ST_DIAG  = 3'b011,
      ST_FATAL = 3'b100
   } state_t;
   typedef enum logic [1:0] {
      FW_IDLE = 2'b00,
      FW_RECV = 2'b01,
      FW_WAIT = 2'b10
   } fw_state_t;
endpackage

// >>> hw/crc32_step.sv
// One byte step of a reflected 32-bit CRC
`timescale 1ns/1ps
`default_nettype none
`include "selftest_params.svh"
module crc32_step (
   input  wire logic [31:0] crc_i,
   input  wire logic [7:0]  data_i,
   output logic      [31:0] crc_o
);
   always_comb begin
      crc_o = crc_i ^ {24'h000000, data_i};
      for (int k = 0; k < 8; k++) begin
         crc_o = crc_o[0] ? ((crc_o >> 1) ^ `CRC_POLY) : (crc_o >> 1);
      end
   end
endmodule
`default_nettype wire

// >>> tb/selftest_chk.sv
// Concurrent checks on the self-test supervisor ports
`timescale 1ns/1ps
`default_nettype none
`include "selftest_params.svh"
module selftest_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        flash_rd_o,
   input wire logic        hash_done_i,
   input wire logic [31:0] hash_digest_i,
   input wire logic        fw_start_i,
   input wire logic [31:0] fw_embedded_digest_i,
   input wire logic        fw_hash_en_o,
   input wire logic        fw_resp_valid_o,
   input wire logic [31:0] fw_resp_code_o,
   input wire logic        io_msg_active_i,
   input wire logic        auth_ok_i,
   input wire logic        engines_enable_o,
   input wire logic        crypto_service_en_o,
   input wire logic        data_out_en_o,
   input wire logic        diag_mode_o,
   input wire logic [2:0]  led_o
);
   // ---------------------------------------------
   // Port relations
   // ---------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_one_pulse:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
         |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer late or longer than one cycle");
   chk_test_on_reset:
      assert property ($fell(rst_i) |-> led_o == 3'h1 && flash_rd_o)
      else $error("self-test not started after reset");
   chk_blocked_testing:
      assert property (led_o[0] |-> !engines_enable_o && !crypto_service_en_o)
      else $error("engines usable during self-test");
   chk_fatal_blocks:
      assert property (led_o[2] |-> !engines_enable_o && !led_o[1])
      else $error("engines usable in fatal state");
   chk_fatal_holds:
      assert property (led_o[2] |=> led_o[2] && $stable(led_o))
      else $error("fatal state left without reset");
   chk_output_quiet:
      assert property ((led_o[0] || led_o[2]) |-> !data_out_en_o)
      else $error("data output during test or error");
   chk_service_auth:
      assert property (!auth_ok_i ##1 !auth_ok_i |-> !crypto_service_en_o)
      else $error("service enabled without login");
   chk_fw_gate:
      assert property ($rose(fw_hash_en_o)
         |-> $past(fw_start_i) && $past(auth_ok_i))
      else $error("image hashing without start and login");
   chk_resp_code:
      assert property (fw_resp_valid_o |-> $past(hash_done_i) && fw_resp_code_o
         == ($past(hash_digest_i) == $past(fw_embedded_digest_i) ?
         `RESP_OK : `RESP_AUTH_FAIL))
      else $error("wrong firmware response code");
   chk_diag_gate:
      assert property ($rose(diag_mode_o)
         |-> !$past(io_msg_active_i) && $past(auth_ok_i))
      else $error("diagnostics entered with messages active");
endmodule
bind crypto_selftest_fw_auth selftest_chk i_chk (.*);
`default_nettype wire

// >>> tb/engine_model.sv
// Behavioural flash image, engine test and hash engine model
`timescale 1ns/1ps
`default_nettype none
`include "selftest_params.svh"
module engine_model #(
   parameter logic [31:0] HASH_VAL = 32'hC3A51E70
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        bad_crc_i,
   input  wire logic [2:0]  fail_idx_i,
   input  wire logic        hash_req_i,
   input  wire logic        flash_rd_i,
   input  wire logic [15:0] flash_addr_i,
   input  wire logic        kat_start_i,
   input  wire logic [1:0]  kat_sel_i,
   input  wire logic        kat_negative_i,
   output logic      [7:0]  flash_data_o,
   output logic             flash_valid_o,
   output logic             flash_last_o,
   output logic             kat_done_o,
   output logic             kat_match_o,
   output logic             hash_done_o,
   output logic      [31:0] hash_digest_o
);
   // ---------------------------------------------
   // Image with its own CRC appended
   // ---------------------------------------------
   logic [7:0]  img [20];
   logic [31:0] c;
   logic [1:0]  sel;
   logic        neg;
   int          kcnt = 0;
   int          hcnt = 0;
   initial begin
      c = `CRC_INIT;
      for (int i = 0; i < 20; i++) begin
         img[i] = (i < 16) ? 8'(i * 29 + 90) : c[8 * (i % 4) +: 8];
         if (i < 16) begin
            c = c ^ {24'h0, img[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
         end
      end
   end
   always @(posedge clk_i) begin
      if (rst_i || !flash_rd_i || flash_valid_o === 1'h1) begin
         flash_valid_o <= 1'h0;
         flash_last_o  <= 1'h0;
         flash_data_o  <= rst_i ? 8'hA5 : ~flash_data_o;
      end else begin
         flash_valid_o <= 1'h1;
         flash_last_o  <= flash_addr_i == 16'h0013;
         flash_data_o  <= img[flash_addr_i[4:0]]
            ^ 8'(bad_crc_i && flash_addr_i == 16'h0003);
      end
   end
   always @(posedge clk_i) begin
      kat_done_o    <= 1'h0;
      kat_match_o   <= 1'($urandom);
      hash_done_o   <= 1'h0;
      hash_digest_o <= $urandom;
      if (kat_start_i === 1'h1) begin
         sel <= kat_sel_i;
         neg <= kat_negative_i;
      end
      if (kcnt == 1) begin
         kat_done_o  <= 1'h1;
         kat_match_o <= ({1'h0, sel} != fail_idx_i) ^ neg;
      end
      if (hcnt == 1) begin
         hash_done_o   <= 1'h1;
         hash_digest_o <= HASH_VAL;
      end
      kcnt <= rst_i ? 0 : kat_start_i === 1'h1 ? int'(1 + $urandom % 6)
         : kcnt > 0 ? kcnt - 1 : 0;
      hcnt <= rst_i ? 0 : hash_req_i === 1'h1 ? int'(2 + $urandom % 6)
         : hcnt > 0 ? hcnt - 1 : 0;
   end
endmodule
`default_nettype wire

// >>> tb/crypto_selftest_fw_auth_bench.sv
// Self-checking bench for the self-test supervisor
`timescale 1ns/1ps
`default_nettype none
`include "selftest_params.svh"
module crypto_selftest_fw_auth_bench;
   // ---------------------------------------------
   // Stimulus, monitor and verdict
   // ---------------------------------------------
   localparam logic [31:0] HASH_VAL = 32'hC3A51E70;
   localparam logic [31:0] ALL      = 32'hFFFFFFFF;
   localparam logic [31:0] ST_MASK  = 32'h0007FF0F;
   logic        clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0;
   logic        wb_stb_i = 1'h0, wb_we_i = 1'h0, fw_start_i = 1'h0;
   logic        fw_end_i = 1'h0, io_msg_active_i = 1'h0, auth_ok_i = 1'h1;
   logic        bad_crc = 1'h0, diag_hreq = 1'h0, hash_req, idle;
   logic [2:0]  fail_idx = 3'h4;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, fw_embedded_digest_i = 32'h0, r, m;
   logic [31:0] wb_dat_o, hash_digest_i, fw_resp_code_o;
   logic        wb_ack_o, flash_rd_o, flash_valid_i, flash_last_i;
   logic        kat_start_o, kat_negative_o, kat_done_i, kat_match_i;
   logic        hash_done_i, fw_hash_en_o, fw_resp_valid_o, diag_mode_o;
   logic        engines_enable_o, crypto_service_en_o, data_out_en_o;
   logic [1:0]  kat_sel_o;
   logic [2:0]  led_o;
   logic [7:0]  flash_data_i;
   logic [15:0] flash_addr_o;
   logic [31:0] exp_q[$], msk_q[$];
   int          errors = 0, samples_checked = 0, k, n;
   assign hash_req = fw_end_i | diag_hreq;
   assign idle = !led_o[0];
   always #10 clk_i = ~clk_i;
   crypto_selftest_fw_auth #(.FLASH_AW(16)) i_dut (.*);
   engine_model #(.HASH_VAL(HASH_VAL)) i_model (
      .clk_i(clk_i), .rst_i(rst_i), .bad_crc_i(bad_crc),
      .fail_idx_i(fail_idx), .hash_req_i(hash_req), .flash_rd_i(flash_rd_o),
      .flash_addr_i(flash_addr_o), .kat_start_i(kat_start_o),
      .kat_sel_i(kat_sel_o), .kat_negative_i(kat_negative_o),
      .flash_data_o(flash_data_i), .flash_valid_o(flash_valid_i),
      .flash_last_o(flash_last_i), .kat_done_o(kat_done_i),
      .kat_match_o(kat_match_i), .hash_done_o(hash_done_i),
      .hash_digest_o(hash_digest_i));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks=%0d errors=%0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wait_hi(ref logic s);
      int c;
      c = 0;
      do begin
         @(posedge clk_i);
         c++;
      end while (s !== 1'h1 && c < 2000);
      if (c >= 2000)
         errors++;
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] msk);
      if (!w) begin
         exp_q.push_back(d & msk);
         msk_q.push_back(msk);
      end
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= w ? d : 32'h0;
      wait_hi(wb_ack_o);
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic restart(input logic bad, input logic [2:0] f);
      bad_crc  <= bad;
      fail_idx <= f;
      rst_i    <= 1'h1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'h0;
      wait_hi(idle);
   endtask
   task automatic fw(input logic [31:0] dig);
      exp_q.push_back(dig === HASH_VAL ? `RESP_OK : `RESP_AUTH_FAIL);
      msk_q.push_back(ALL);
      fw_embedded_digest_i <= dig;
      fw_start_i <= 1'h1;
      @(posedge clk_i);
      fw_start_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      fw_end_i <= 1'h1;
      @(posedge clk_i);
      fw_end_i <= 1'h0;
      wait_hi(fw_resp_valid_o);
      @(posedge clk_i);
   endtask
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'h1 && !wb_we_i || fw_resp_valid_o === 1'h1) begin
         if (exp_q.size() == 0) begin
            chk(32'h1, 32'h0);
         end else begin
            m = msk_q.pop_front();
            chk((fw_resp_valid_o === 1'h1 ? fw_resp_code_o : wb_dat_o) & m,
                exp_q.pop_front());
         end
      end
   end
   initial begin
      void'($urandom(84));
      restart(1'h1, 3'h4);
      wb(1'h0, `REG_STATUS, 32'h00040002, 32'h00070003);
      chk({26'h0, led_o, engines_enable_o, crypto_service_en_o,
           data_out_en_o}, 32'h20);
      for (k = 0; k < 4; k++) begin
         restart(1'h0, 3'(k));
         wb(1'h0, `REG_STATUS, 32'h00040005 | (32'h100 << k), ST_MASK);
      end
      restart(1'h0, 3'h4);
      wb(1'h0, `REG_STATUS, 32'h00020009, ST_MASK);
      chk({29'h0, led_o}, 32'h2);
      chk({29'h0, engines_enable_o, crypto_service_en_o,
           data_out_en_o}, 32'h7);
      wb(1'h0, 8'h40, 32'h0, ALL);
      r = $urandom;
      wb(1'h1, `REG_CRC_REF, r, ALL);
      wb(1'h0, `REG_CRC_REF, r, ALL);
      wb(1'h0, `REG_DIGEST, 32'h0, ALL);
      auth_ok_i  <= 1'h0;
      fw_start_i <= 1'h1;
      @(posedge clk_i);
      fw_start_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      chk({30'h0, fw_hash_en_o, crypto_service_en_o}, 32'h0);
      wb(1'h0, `REG_LOGIN, 32'h0, 32'h1);
      auth_ok_i <= 1'h1;
      fw(HASH_VAL);
      fw(HASH_VAL ^ ($urandom | 32'h1));
      wb(1'h0, `REG_FW_RESP, `RESP_AUTH_FAIL, ALL);
      io_msg_active_i <= 1'h1;
      wb(1'h1, `REG_DIAG, 32'h1, ALL);
      wb(1'h0, `REG_DIAG, 32'h0, 32'h1);
      io_msg_active_i <= 1'h0;
      for (k = 0; k < 8; k++) begin
         restart(1'h0, 3'h4);
         n = $urandom % 2;
         fail_idx <= n ? 3'(k % 4) : 3'h4;
         wb(1'h1, `REG_DIAG, 32'(k % 4) << 4 | 32'(k / 4) << 1 | 32'h1, ALL);
         wait_hi(kat_done_i);
         @(posedge clk_i);
         wb(1'h0, `REG_DIAG, n ? 32'h3 : 32'h7, 32'h7);
      end
      restart(1'h0, 3'h4);
      wb(1'h1, `REG_DIAG, 32'h5, ALL);
      diag_hreq <= 1'h1;
      @(posedge clk_i);
      diag_hreq <= 1'h0;
      wait_hi(hash_done_i);
      @(posedge clk_i);
      wb(1'h0, `REG_DIGEST, HASH_VAL, ALL);
      chk({31'h0, diag_mode_o}, 32'h1);
      restart(1'h0, 3'h4);
      wb(1'h0, `REG_STATUS, 32'h00020009, ST_MASK);
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      complete_run();
   end
endmodule
`default_nettype wire
